// ### rf_transmitter_power_sequencer.sv
// power state and modulation sequencer of the integrated transmitter
`timescale 1ns/1ns
`include "rf_seq_defs.svh"

// Behaviour
// - both enables low gives full standby
// - enable alone runs oscillator, pll, clock out
// - lock and stable clock after lock time
// - both enables high: amplifier on, ask keying
// - vco locks at 32 times crystal
// - closed switch gives lower output frequency
// - clock output is crystal divided by four
module rf_transmitter_power_sequencer #(
  parameter int LOCK_CYCLES = `LOCK_CYCLES,
  parameter int MULT_W = `PLL_MULT_W
) (
  // control clock and reset
  input wire logic clk,
  input wire logic rstn,
  // crystal clock
  input wire logic xtal_clk,
  // pins driven by the controller
  input wire logic tx_enable,
  input wire logic amp_on,
  input wire logic cap_switch_closed,
  // power and status
  output logic standby,
  output logic osc_run,
  output logic pll_locked,
  output logic amp_active,
  output logic freq_low,
  output logic [MULT_W-1:0] pll_mult,
  // clock toward the controller
  output logic clk_out
);
  // three pins pass the synchronisers
  localparam int NPIN = 3;
  localparam int LW = $clog2(LOCK_CYCLES + 1);

  // true in states where oscillator and pll are powered
  function automatic logic osc_powered(input rf_seq_pkg::power_state_t s);
    osc_powered = (s != rf_seq_pkg::ST_STANDBY);
  endfunction

  // synchroniser stages and agreed levels
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] s1_reg;
  logic [NPIN-1:0] s2_reg;
  logic [NPIN-1:0] s3_reg;
  logic [NPIN-1:0] pin_reg;
  logic en_lvl;
  logic amp_lvl;
  logic cap_lvl;
  // power state and lock timer
  rf_seq_pkg::power_state_t state_reg;
  rf_seq_pkg::power_state_t state_next;
  logic [LW-1:0] lock_cnt_reg;

  // pins gathered for the synchronisers
  assign pin_raw = {cap_switch_closed, amp_on, tx_enable};

  // =========================================
  // pin synchronisers: three flops, change taken when second and third agree
  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++) begin : g_sync
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          s1_reg[gi] <= 1'b0;
          s2_reg[gi] <= 1'b0;
          s3_reg[gi] <= 1'b0;
          pin_reg[gi] <= 1'b0;
        end else begin
          s1_reg[gi] <= pin_raw[gi];
          s2_reg[gi] <= s1_reg[gi];
          s3_reg[gi] <= s2_reg[gi];
          if (s2_reg[gi] == s3_reg[gi]) begin
            pin_reg[gi] <= s3_reg[gi];
          end
        end
      end
    end
  endgenerate

  // agreed pin levels
  assign en_lvl = pin_reg[0];
  assign amp_lvl = pin_reg[1];
  assign cap_lvl = pin_reg[2];

  // =========================================
  // power state selection from the two enables
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      rf_seq_pkg::ST_STANDBY: begin
        if (en_lvl) begin
          state_next = rf_seq_pkg::ST_LOCKING;
        end
      end
      rf_seq_pkg::ST_LOCKING: begin
        if (!en_lvl) begin
          state_next = rf_seq_pkg::ST_STANDBY;
        end else if (lock_cnt_reg == LW'(LOCK_CYCLES - 1)) begin
          state_next = amp_lvl ? rf_seq_pkg::ST_TRANSMIT : rf_seq_pkg::ST_READY;
        end
      end
      rf_seq_pkg::ST_READY: begin
        if (!en_lvl) begin
          state_next = rf_seq_pkg::ST_STANDBY;
        end else if (amp_lvl) begin
          state_next = rf_seq_pkg::ST_TRANSMIT;
        end
      end
      rf_seq_pkg::ST_TRANSMIT: begin
        if (!en_lvl) begin
          state_next = rf_seq_pkg::ST_STANDBY;
        end else if (!amp_lvl) begin
          state_next = rf_seq_pkg::ST_READY;
        end
      end
      default: begin
        state_next = rf_seq_pkg::ST_STANDBY;
      end
    endcase
  end

  // state register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= rf_seq_pkg::ST_STANDBY;
    end else begin
      state_reg <= state_next;
    end
  end

  // =========================================
  // lock timer, restarted whenever the oscillator is off
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lock_cnt_reg <= '0;
    end else if (state_reg != rf_seq_pkg::ST_LOCKING) begin
      lock_cnt_reg <= '0;
    end else begin
      lock_cnt_reg <= lock_cnt_reg + 1'b1;
    end
  end

  // =========================================
  // registered power and status outputs, one flop per concern
  // standby while the enable is low, whatever the amplifier pin
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      standby <= 1'b1;
    end else begin
      standby <= !osc_powered(state_next);
    end
  end

  // oscillator, pll and clock driver powered
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      osc_run <= 1'b0;
    end else begin
      osc_run <= osc_powered(state_next);
    end
  end

  // lock reported once the lock timer has run out
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pll_locked <= 1'b0;
    end else begin
      pll_locked <= osc_powered(state_next) && (state_next != rf_seq_pkg::ST_LOCKING);
    end
  end

  // amplifier on only in transmit, which is entered after lock
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      amp_active <= 1'b0;
    end else begin
      amp_active <= (state_next == rf_seq_pkg::ST_TRANSMIT);
    end
  end

  // vco multiple reported while the pll is powered
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pll_mult <= MULT_W'(`PLL_MULT_RST);
    end else begin
      pll_mult <= osc_powered(state_next) ? MULT_W'(`PLL_MULT) : MULT_W'(`PLL_MULT_RST);
    end
  end

  // closed load capacitor pulls the carrier down, only while powered
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      freq_low <= 1'b0;
    end else begin
      freq_low <= osc_powered(state_next) & cap_lvl;
    end
  end

  // =========================================
  // clock output divider on the crystal clock
  // only levels cross into the crystal domain, never control clock pulses
  xtal_clk_out #(
    .DIV(`CLKOUT_DIV)
  ) u_clk_out (
    .xtal_clk(xtal_clk),
    .rstn(rstn),
    .osc_run(osc_run),
    .pll_locked(pll_locked),
    .clk_out(clk_out)
  );
endmodule

// ### rf_seq_defs.svh
// timing constants and fixed figures of the transmitter sequencer
`ifndef RF_SEQ_DEFS_SVH
`define RF_SEQ_DEFS_SVH

// control clock rate in MHz
`define CLK_MHZ 100
// lock time of crystal oscillator and pll, in microseconds
`define LOCK_TIME_US 1000
// cycles of clk for the lock time, longest time rounds down
`define LOCK_CYCLES (`LOCK_TIME_US * `CLK_MHZ)
// clock output divides the crystal by this figure
`define CLKOUT_DIV 4
// vco runs at this multiple of the crystal frequency
`define PLL_MULT 32
// width of the multiplier report
`define PLL_MULT_W 6
// reset value of the multiplier report
`define PLL_MULT_RST 6'h00

`endif

// ### rf_seq_pkg.sv
// types shared by the transmitter sequencer
package rf_seq_pkg;
  typedef enum logic [1:0] {
    ST_STANDBY,
    ST_LOCKING,
    ST_READY,
    ST_TRANSMIT
  } power_state_t;
endpackage

// ### xtal_clk_out.sv
// crystal domain clock output divider
`timescale 1ns/1ns
`include "rf_seq_defs.svh"

module xtal_clk_out #(
  parameter int DIV = `CLKOUT_DIV
) (
  // crystal clock domain
  input wire logic xtal_clk,
  input wire logic rstn,
  // levels from the control domain
  input wire logic osc_run,
  input wire logic pll_locked,
  // clock toward the controller
  output logic clk_out
);
  localparam int CW = $clog2(DIV);
  localparam int NLVL = 2;

  logic [NLVL-1:0] lvl_raw;
  logic [NLVL-1:0] s1_reg;
  logic [NLVL-1:0] s2_reg;
  logic [NLVL-1:0] s3_reg;
  logic [NLVL-1:0] lvl_reg;
  logic run_lvl;
  logic lock_lvl;
  logic [CW-1:0] div_reg;

  // levels gathered for the crossing
  assign lvl_raw = {pll_locked, osc_run};

  // =========================================
  // level crossings into the crystal domain, taken when stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < NLVL; gi++) begin : g_sync
      always_ff @(posedge xtal_clk or negedge rstn) begin
        if (!rstn) begin
          s1_reg[gi] <= 1'b0;
          s2_reg[gi] <= 1'b0;
          s3_reg[gi] <= 1'b0;
          lvl_reg[gi] <= 1'b0;
        end else begin
          s1_reg[gi] <= lvl_raw[gi];
          s2_reg[gi] <= s1_reg[gi];
          s3_reg[gi] <= s2_reg[gi];
          if (s2_reg[gi] == s3_reg[gi]) begin
            lvl_reg[gi] <= s3_reg[gi];
          end
        end
      end
    end
  endgenerate

  assign run_lvl = lvl_reg[0];
  assign lock_lvl = lvl_reg[1];

  // =========================================
  // divide crystal by four while the oscillator runs
  always_ff @(posedge xtal_clk or negedge rstn) begin
    if (!rstn) begin
      div_reg <= '0;
    end else if (!run_lvl) begin
      div_reg <= '0;
    end else if (div_reg == CW'(DIV - 1)) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_reg + 1'b1;
    end
  end

  // output held low until lock is reported, so no pulses reach the controller before lock
  always_ff @(posedge xtal_clk or negedge rstn) begin
    if (!rstn) begin
      clk_out <= 1'b0;
    end else begin
      clk_out <= run_lvl & lock_lvl & (div_reg >= CW'(DIV / 2));
    end
  end
endmodule

// ### rf_seq_props.sv
// port checks of the transmitter sequencer
`timescale 1ns/1ns
module rf_seq_props #(
  parameter int LOCK_CYCLES = 20,
  parameter int MULT_W = 6
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // pins from the controller
  input wire logic tx_enable,
  input wire logic amp_on,
  input wire logic cap_switch_closed,
  // power and status
  input wire logic standby,
  input wire logic osc_run,
  input wire logic pll_locked,
  input wire logic amp_active,
  input wire logic freq_low,
  input wire logic [MULT_W-1:0] pll_mult
);
  int cnt;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // cycles powered, saturating
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) cnt <= 0;
    else if (!osc_run) cnt <= 0;
    else if (cnt < LOCK_CYCLES + 4) cnt <= cnt + 1;
  end
  // ==== assertions
  standby_off_a: assert property (standby |-> !osc_run && !amp_active && !freq_low && pll_mult == 0)
    else $error("standby not quiet");
  amp_lock_a: assert property (amp_active |-> pll_locked && osc_run)
    else $error("amplifier before lock");
  vco_mult_a: assert property (osc_run |-> pll_mult == 32 && !standby)
    else $error("wrong vco multiple");
  power_up_a: assert property ($rose(tx_enable) |-> ##[2:8] osc_run)
    else $error("oscillator late");
  lock_early_a: assert property (pll_locked && osc_run |-> cnt >= LOCK_CYCLES - 2)
    else $error("lock too early");
  lock_late_a: assert property (cnt == LOCK_CYCLES + 3 |-> pll_locked)
    else $error("lock too late");
  ask_key_a: assert property ($rose(amp_on) && pll_locked |-> ##[2:8] amp_active)
    else $error("amplifier not keyed");
  fsk_low_a: assert property ($rose(cap_switch_closed) && pll_locked |-> ##[2:8] freq_low)
    else $error("frequency not pulled");
  power_down_a: assert property ($fell(tx_enable) |-> ##[2:8] standby)
    else $error("standby late");
  // main scenarios reached
  cover property ($rose(pll_locked));
  cover property ($rose(amp_active));
  cover property ($rose(freq_low));
endmodule

// ### ctrl_model.sv
// controller model driving the transmitter pins
`timescale 1ns/1ns
module ctrl_model #(
  parameter int WAIT = 30,
  parameter int BIT = 3
) (
  // controller rc clock
  input wire logic clk,
  // transmitter clock on the counter-zero input
  input wire logic counter_zero_input,
  // pins toward the transmitter
  output logic tx_enable,
  output logic amp_on,
  output logic cap_switch_closed
);
  // ==== pin sequences
  // pins idle low
  initial begin
    tx_enable = 1'b0;
    amp_on = 1'b0;
    cap_switch_closed = 1'b0;
  end
  // woken on rc clock, enable the transmitter
  task automatic start();
    @(posedge clk);
    tx_enable <= 1'b1;
    repeat (9) @(posedge clk);
  endtask
  // amplifier kept low over the lock wait, with margin
  task automatic settle();
    repeat (WAIT) @(posedge clk);
  endtask
  // serial shift unit: ask keys the amplifier, fsk keys the load switch
  // bit time counted on the transmitter clock, pins change on the rc clock
  task automatic send_bit(input int fsk, input logic b);
    if (fsk != 0 && amp_on == 1'b0) begin
      @(posedge clk);
      amp_on <= 1'b1;
      repeat (BIT) @(posedge counter_zero_input);
    end
    @(posedge clk);
    amp_on <= (fsk != 0) ? 1'b1 : b;
    cap_switch_closed <= (fsk != 0) ? b : 1'b0;
    repeat (BIT) @(posedge counter_zero_input);
    @(posedge clk);
  endtask
  // amplifier off, back to rc clock, then disable
  task automatic stop();
    @(posedge clk);
    amp_on <= 1'b0;
    cap_switch_closed <= 1'b0;
    repeat (4) @(posedge clk);
    tx_enable <= 1'b0;
  endtask
endmodule

// ### tb_top.sv
// self-checking bench of the transmitter sequencer
`timescale 1ns/1ns
module tb_top;
  localparam int LOCK = 20;
  logic clk = 0, xtal_clk = 0, rstn = 0, b;
  logic tx_enable, amp_on, cap_switch_closed, standby, osc_run, pll_locked, amp_active, freq_low, clk_out;
  logic [5:0] pll_mult;
  logic [7:0] w;
  logic [31:0] seed = 32'h0000_3785;
  logic q[$];
  int n_errors = 0, tests_run = 0;
  // ==== clocks and instances
  always #5 clk = ~clk;
  initial #2 forever #6 xtal_clk = ~xtal_clk;
  ctrl_model #(.WAIT(LOCK + 10)) ctrl (.clk(clk), .counter_zero_input(clk_out), .tx_enable(tx_enable),
    .amp_on(amp_on), .cap_switch_closed(cap_switch_closed));
  rf_transmitter_power_sequencer #(.LOCK_CYCLES(LOCK)) DUT (.clk(clk), .rstn(rstn), .xtal_clk(xtal_clk),
    .tx_enable(tx_enable), .amp_on(amp_on), .cap_switch_closed(cap_switch_closed), .standby(standby),
    .osc_run(osc_run), .pll_locked(pll_locked), .amp_active(amp_active), .freq_low(freq_low),
    .pll_mult(pll_mult), .clk_out(clk_out));
  // xorshift step of the random source
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction
  // compare one result
  task automatic chk(input string nm, input int e, input logic [7:0] g);
    tests_run++;
    if (g !== 8'(e)) begin
      n_errors++;
      $display("ERROR %s exp %0d got %0d", nm, e, g);
    end
  endtask
  // expected power state
  task automatic pwr(input int on, input int lk);
    #1;
    chk("standby", !on, standby);
    chk("osc_run", on, osc_run);
    chk("locked", lk, pll_locked);
    chk("mult", on * 32, pll_mult);
  endtask
  // sample clock output on eight crystal edges from a rise
  task automatic period();
    do @(negedge xtal_clk); while (clk_out !== 1'b0);
    do @(negedge xtal_clk); while (clk_out !== 1'b1);
    for (int i = 0; i < 8; i++) begin
      w = {w[6:0], clk_out};
      @(negedge xtal_clk);
    end
  endtask
  // verdict
  task automatic final_report();
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // main sequence: ask pass, then fsk pass with a reset in mid-run
  initial begin
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    pwr(0, 0);
    for (int f = 0; f < 2; f++) begin
      ctrl.start();
      pwr(1, 0);
      chk("clk_out", 0, clk_out);
      if (f == 1) begin
        @(posedge clk);
        rstn <= 1'b0;
        pwr(0, 0);
        chk("clk_out", 0, clk_out);
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        repeat (9) @(posedge clk);
        pwr(1, 0);
      end
      ctrl.settle();
      pwr(1, 1);
      period();
      chk("clk_wave", 8'hcc, w);
      for (int i = 0; i < 8; i++) begin
        seed = xorshift(seed);
        q.push_back(seed[0]);
      end
      while (q.size() > 0) begin
        b = q.pop_front();
        ctrl.send_bit(f, b);
        #1;
        chk("amp", f | b, amp_active);
        chk("freq_low", f & b, freq_low);
      end
      ctrl.stop();
      repeat (10) @(posedge clk);
      pwr(0, 0);
    end
    final_report();
  end
  // hang guard
  initial begin
    #20000;
    n_errors++;
    final_report();
  end
endmodule
bind rf_transmitter_power_sequencer rf_seq_props #(.LOCK_CYCLES(LOCK_CYCLES), .MULT_W(MULT_W)) props (
  .clk(clk), .rstn(rstn), .tx_enable(tx_enable), .amp_on(amp_on), .cap_switch_closed(cap_switch_closed),
  .standby(standby), .osc_run(osc_run), .pll_locked(pll_locked), .amp_active(amp_active),
  .freq_low(freq_low), .pll_mult(pll_mult));
